// File: led_intrusion_chk.sv
`timescale 1ns/1ps
module led_intrusion_chk (
    // clock, reset and power events
    input logic clk_i, rst_i, main_power_up_i, standby_power_up_i, main_power_off_i,
    input logic supply_control_straps_disable_i,
    // bus
    input logic cyc_i, stb_i, we_i, ack_o, err_o,
    input logic [9:0] adr_i,
    input logic [3:0] sel_i,
    input logic [31:0] dat_i,
    // configuration
    input logic thermistor_select_o, infrared_receive_one_select_o, two_led_o,
    input logic infrared_receive_two_select_zero_select_o, power_led_keep_o, intrusion_status_o,
    input logic [1:0] led_mode_o,
    input logic [2:0] second_led_blink_o, first_led_blink_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a request counts only when no answer is still out
    wire tk = cyc_i && stb_i && !ack_o && !err_o;
    wire tu = tk && adr_i != 10'h0AC && adr_i != 10'h0B0;
    wire wp = tk && we_i && sel_i[0] && adr_i == 10'h0AC;
    wire wb = tk && we_i && sel_i[0] && adr_i == 10'h0B0;
    chk_unmapped_err: assert property (tu |=> err_o && !ack_o)
        else $error("unmapped access not refused");
    chk_pin_write: assert property (wp |=> {thermistor_select_o, infrared_receive_one_select_o,
        infrared_receive_two_select_zero_select_o} == {$past(dat_i[6]), $past(dat_i[1:0])})
        else $error("pin select write lost");
    chk_blink_write: assert property (wb |=>
        {two_led_o, second_led_blink_o, first_led_blink_o} == {$past(dat_i[7]), $past(dat_i[5:0])})
        else $error("blink write lost");
    chk_keep_mode: assert property (power_led_keep_o |-> led_mode_o == 2'h2)
        else $error("keep outside mode two");
    chk_off_clears: assert property (main_power_off_i |=> !power_led_keep_o)
        else $error("keep not cleared");
    chk_marked_rate: assert property ((standby_power_up_i || main_power_off_i) && led_mode_o == 2'h1
        |=> first_led_blink_o == 3'h3) else $error("marked rate not loaded");
    chk_power_up: assert property (main_power_up_i |=> intrusion_status_o && !two_led_o
        && led_mode_o == {1'h0, $past(supply_control_straps_disable_i)}) else $error("bad power-up");
    chk_status_hold: assert property (intrusion_status_o && !wp |=> intrusion_status_o)
        else $error("status lost");
endmodule : led_intrusion_chk
bind led_intrusion_pin_config led_intrusion_chk u_led_intrusion_chk (.*);

// File: led_intrusion_pin_config.sv
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module led_intrusion_pin_config (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // power events (pulses from power logic, same clock)
    input wire logic main_power_up_i,
    input wire logic standby_power_up_i,
    input wire logic main_power_off_i,
    input wire logic supply_control_straps_disable_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // pins
    input wire logic chassis_intrusion_input_i,
    // configuration outputs
    output logic thermistor_select_o,
    output logic [1:0] led_mode_o,
    output logic infrared_receive_one_select_o,
    output logic infrared_receive_two_select_zero_select_o,
    output logic two_led_o,
    output logic power_led_keep_o,
    output logic [2:0] second_led_blink_o,
    output logic [2:0] first_led_blink_o,
    output logic intrusion_status_o
);
    // ----------------------------------------------------------------
    // pin synchroniser and edge detect
    // ----------------------------------------------------------------
    logic intr_meta;
    logic intr_sync;
    logic intr_prev;
    always_ff @(posedge clk_i) begin
        intr_meta <= chassis_intrusion_input_i;
        intr_sync <= intr_meta;
        intr_prev <= intr_sync;
    end
    // active transition taken as rising edge; limitation: polarity fixed
    wire intrusion_edge = intr_sync & ~intr_prev;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic index_match(input logic [7:0] index, input logic [7:0] target);
        index_match = (index == target);
    endfunction : index_match

    function automatic logic [2:0] blink_field(input logic [7:0] cfg, input int lo);
        blink_field = cfg[lo +: 3];
    endfunction : blink_field

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire req = cyc_i & stb_i & ~ack_o & ~err_o;
    wire word_ok = (adr_i[1:0] == 2'h0);
    wire [7:0] word_index = adr_i[9:2];
    wire hit_pin = word_ok & index_match(word_index, led_intrusion_pkg::pin_cfg_index);
    wire hit_blink = word_ok & index_match(word_index, led_intrusion_pkg::blink_cfg_index);
    wire hit_any = hit_pin | hit_blink;

    // only the low byte lane carries register data; other lanes are ignored
    wire lane_ok = sel_i[0];
    wire wr_pin = req & we_i & lane_ok & hit_pin;
    wire wr_blink = req & we_i & lane_ok & hit_blink;

    // main power-up owns the blink register for that cycle, a write then is dropped
    wire blink_write = wr_blink & ~main_power_up_i;

    // ----------------------------------------------------------------
    // power-up defaults
    // ----------------------------------------------------------------
    wire led_mode_default = supply_control_straps_disable_i;
    wire [1:0] power_up_mode = led_mode_default ? led_intrusion_pkg::led_hardware_one
                                                : led_intrusion_pkg::led_software;

    // these fields are reinitialised; on main power-up two_led is also cleared and the intrusion flag set, the rest is battery-backed
    wire reinit = rst_i | main_power_up_i;

    // ----------------------------------------------------------------
    // register state: no power-loss clear except the keep bit on main power-off, it models battery-backed storage
    // ----------------------------------------------------------------
    logic therm_sel;
    logic intr_status;
    logic [1:0] led_mode;
    logic ir1_sel;
    logic ir2_sel;
    logic two_led;
    logic power_led_keep;
    logic [2:0] second_blink;
    logic [2:0] first_blink;

    wire hw1 = (led_mode == led_intrusion_pkg::led_hardware_one);
    wire hw2 = (led_mode == led_intrusion_pkg::led_hardware_two);
    wire load_marked = hw1 & (standby_power_up_i | main_power_off_i);

    // ----------------------------------------------------------------
    // next values
    // ----------------------------------------------------------------
    wire next_therm_sel = wr_pin ?
        dat_i[led_intrusion_pkg::thermistor_sel_bit] :
        therm_sel;
    wire [1:0] next_led_mode = wr_pin ?
        dat_i[led_intrusion_pkg::led_mode_hi_bit:led_intrusion_pkg::led_mode_lo_bit] :
        led_mode;
    wire next_ir1_sel = wr_pin ?
        dat_i[led_intrusion_pkg::infrared_one_sel_bit] :
        ir1_sel;
    wire next_ir2_sel = wr_pin ?
        dat_i[led_intrusion_pkg::infrared_two_sel_bit] :
        ir2_sel;

    wire intr_clear = wr_pin & ~dat_i[led_intrusion_pkg::intrusion_status_bit];
    // set wins over a software clear in the same cycle
    wire next_intr_status = (main_power_up_i | intrusion_edge) ? 1'b1 :
        intr_clear ? 1'b0 :
        intr_status;

    wire next_two_led = blink_write ?
        dat_i[led_intrusion_pkg::two_led_bit] :
        two_led;
    // a power-off in the same cycle as a write still clears the keep bit
    wire next_power_led_keep = main_power_off_i ? led_intrusion_pkg::power_led_keep_off :
        blink_write ? dat_i[led_intrusion_pkg::power_led_keep_bit] :
        power_led_keep;
    wire [2:0] next_second_blink = blink_write ?
        blink_field(dat_i[7:0], led_intrusion_pkg::second_blink_lo_bit) :
        second_blink;
    // the marked rate beats a write that lands in the same cycle
    wire [2:0] next_first_blink = load_marked ? led_intrusion_pkg::blink_marked :
        blink_write ? blink_field(dat_i[7:0], led_intrusion_pkg::first_blink_lo_bit) :
        first_blink;

    // ----------------------------------------------------------------
    // pin and mode register fields
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reinit) begin
            therm_sel <= led_intrusion_pkg::thermistor_sel_reset;
        end else begin
            therm_sel <= next_therm_sel;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reinit) begin
            led_mode <= power_up_mode;
        end else begin
            led_mode <= next_led_mode;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reinit) begin
            ir1_sel <= led_intrusion_pkg::infrared_sel_reset;
        end else begin
            ir1_sel <= next_ir1_sel;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reinit) begin
            ir2_sel <= led_intrusion_pkg::infrared_sel_reset;
        end else begin
            ir2_sel <= next_ir2_sel;
        end
    end

    // ----------------------------------------------------------------
    // intrusion flag
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            intr_status <= led_intrusion_pkg::intrusion_status_reset;
        end else begin
            intr_status <= next_intr_status;
        end
    end

    // ----------------------------------------------------------------
    // blink register fields
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            two_led <= led_intrusion_pkg::blink_cfg_reset[led_intrusion_pkg::two_led_bit];
        end else if (main_power_up_i) begin
            two_led <= led_intrusion_pkg::two_led_power_up;
        end else begin
            two_led <= next_two_led;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_led_keep <=
                led_intrusion_pkg::blink_cfg_reset[led_intrusion_pkg::power_led_keep_bit];
        end else begin
            power_led_keep <= next_power_led_keep;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            second_blink <= blink_field(led_intrusion_pkg::blink_cfg_reset,
                                        led_intrusion_pkg::second_blink_lo_bit);
        end else begin
            second_blink <= next_second_blink;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_blink <= blink_field(led_intrusion_pkg::blink_cfg_reset,
                                       led_intrusion_pkg::first_blink_lo_bit);
        end else begin
            first_blink <= next_first_blink;
        end
    end

    // ----------------------------------------------------------------
    // read data and answer
    // ----------------------------------------------------------------
    wire [7:0] blink_cfg = {two_led, power_led_keep, second_blink, first_blink};
    wire [7:0] pin_read = {1'b0, therm_sel, intr_sync, intr_status, led_mode,
                           ir1_sel, ir2_sel};
    wire [7:0] read_mux = hit_pin ? pin_read : (hit_blink ? blink_cfg : 8'h00);

    // every mapped access is answered one cycle after it is taken
    wire next_ack = req & hit_any;
    wire next_err = req & ~hit_any;
    // reads have no side effects, so the data path may follow every cycle
    wire [31:0] next_dat = {24'h00_0000, read_mux};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= next_ack;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_o <= 1'b0;
        end else begin
            err_o <= next_err;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else begin
            dat_o <= next_dat;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign thermistor_select_o = therm_sel;
    assign led_mode_o = led_mode;
    assign infrared_receive_one_select_o = ir1_sel;
    assign infrared_receive_two_select_zero_select_o = ir2_sel;
    assign two_led_o = two_led;

    // only meaningful in hardware mode 2
    assign power_led_keep_o = power_led_keep & hw2;

    assign second_led_blink_o = second_blink;
    assign first_led_blink_o = first_blink;
    assign intrusion_status_o = intr_status;
endmodule : led_intrusion_pin_config

// File: led_intrusion_pkg.sv
package led_intrusion_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses are four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] pin_cfg_index = 8'h2B;
    localparam logic [7:0] blink_cfg_index = 8'h2C;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int thermistor_sel_bit = 6;
    localparam int intrusion_level_bit = 5;
    localparam int intrusion_status_bit = 4;
    localparam int led_mode_hi_bit = 3;
    localparam int led_mode_lo_bit = 2;
    localparam int infrared_one_sel_bit = 1;
    localparam int infrared_two_sel_bit = 0;
    localparam int two_led_bit = 7;
    localparam int power_led_keep_bit = 6;
    localparam int second_blink_lo_bit = 3;
    localparam int first_blink_lo_bit = 0;
    // ----------------------------------------------------------------
    // encodings and reset values
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        led_software = 2'b00,
        led_hardware_one = 2'b01,
        led_hardware_two = 2'b10,
        led_reserved = 2'b11
    } led_mode_type;
    localparam logic [2:0] blink_off = 3'h0;
    localparam logic [2:0] blink_marked = 3'h3;
    localparam logic [7:0] blink_cfg_reset = 8'h00;
    localparam logic thermistor_sel_reset = 1'b0;
    localparam logic intrusion_status_reset = 1'b1;
    localparam logic infrared_sel_reset = 1'b0;
    localparam logic two_led_power_up = 1'b0;
    localparam logic power_led_keep_off = 1'b0;
endpackage : led_intrusion_pkg

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic [2:0] op; logic [9:0] adr; logic [7:0] dat;} row_type;
    localparam logic [9:0] pa = 10'h0AC;
    localparam logic [9:0] ba = 10'h0B0;
    localparam logic [9:0] ua = 10'h0AD;
    // ----------------------------------------------------------------
    // op 0 read, 1 write, 2 main up, 3 standby up, 4 main off, 5 pin
    // ----------------------------------------------------------------
    localparam row_type rows [28] = '{'{3'h0, pa, 8'h10}, '{3'h0, ba, 8'h00}, '{3'h1, pa, 8'h53},
        '{3'h0, pa, 8'h53}, '{3'h1, pa, 8'h08}, '{3'h0, pa, 8'h08}, '{3'h1, ba, 8'hDB},
        '{3'h0, ba, 8'hDB}, '{3'h1, ua, 8'hFF}, '{3'h0, ua, 8'h00}, '{3'h0, ba, 8'hDB},
        '{3'h4, ba, 8'h00}, '{3'h0, ba, 8'h9B}, '{3'h1, pa, 8'h04}, '{3'h1, ba, 8'h80},
        '{3'h3, ba, 8'h00}, '{3'h0, ba, 8'h83}, '{3'h1, ba, 8'h80}, '{3'h4, ba, 8'h00},
        '{3'h0, ba, 8'h83}, '{3'h5, ba, 8'h01}, '{3'h0, pa, 8'h34}, '{3'h1, pa, 8'h04},
        '{3'h0, pa, 8'h24}, '{3'h5, ba, 8'h00}, '{3'h2, ba, 8'h00}, '{3'h0, pa, 8'h10},
        '{3'h0, ba, 8'h03}};
    logic clk_i, rst_i, main_power_up_i, standby_power_up_i, main_power_off_i, cyc_i, stb_i;
    logic we_i, supply_control_straps_disable_i, chassis_intrusion_input_i, ack_o, err_o;
    logic [9:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o;
    logic thermistor_select_o, infrared_receive_one_select_o, two_led_o, power_led_keep_o;
    logic infrared_receive_two_select_zero_select_o, intrusion_status_o;
    logic [1:0] led_mode_o;
    logic [2:0] second_led_blink_o, first_led_blink_o;
    logic [7:0] rd, rsp;
    int err_count, n_checks;
    led_intrusion_pin_config u_led_intrusion_pin_config (.*);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, 4'hF, 24'h0, d};
        do begin @(posedge clk_i); n++; end while (!(ack_o || err_o) && n < 50);
        rd = dat_o[7:0];
        rsp = {6'h0, err_o, ack_o};
        {cyc_i, stb_i} <= 2'h0;
    endtask : bus
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    initial begin clk_i = 1'b0; forever #25 clk_i = ~clk_i; end
    // a hang costs at most 2000 cycles; the run needs about 130
    initial begin #100000; err_count++; final_report(); end
    initial begin
        {rst_i, main_power_up_i, standby_power_up_i, main_power_off_i, cyc_i} = 5'h10;
        {stb_i, we_i, supply_control_straps_disable_i, chassis_intrusion_input_i} = 4'h0;
        {adr_i, sel_i, dat_i} = 46'h0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 28; i++) begin
            if (rows[i].op < 3'h2) begin
                bus(rows[i].op[0], rows[i].adr, rows[i].dat);
                check(rsp, (rows[i].adr == ua) ? 8'h02 : 8'h01);
                if (!rows[i].op[0] && rows[i].adr != ua) check(rd, rows[i].dat);
            end else begin
                @(posedge clk_i);
                {main_power_up_i, standby_power_up_i, main_power_off_i} <=
                    {rows[i].op == 3'h2, rows[i].op == 3'h3, rows[i].op == 3'h4};
                if (rows[i].op == 3'h5) chassis_intrusion_input_i <= rows[i].dat[0];
                @(posedge clk_i);
                {main_power_up_i, standby_power_up_i, main_power_off_i} <= 3'h0;
                repeat (4) @(posedge clk_i);
            end
        end
        {rst_i, supply_control_straps_disable_i} <= 2'h3;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, pa, 8'h00);
        check(rd, 8'h14);
        check({6'h0, led_mode_o}, 8'h01);
        check({5'h0, thermistor_select_o, infrared_receive_one_select_o,
               infrared_receive_two_select_zero_select_o}, 8'h00);
        bus(1'b1, pa, 8'h08);
        bus(1'b1, ba, 8'h40);
        check({7'h0, power_led_keep_o}, 8'h01);
        check({7'h0, two_led_o}, 8'h00);
        @(posedge clk_i);
        main_power_off_i <= 1'b1;
        @(posedge clk_i);
        main_power_off_i <= 1'b0;
        @(posedge clk_i);
        check({7'h0, power_led_keep_o}, 8'h00);
        final_report();
    end
endmodule : tb_top
